// [serial_msg_ack.sv]
`include "serial_msg_regs.svh"

module serial_msg_ack #(
  parameter int OVS_DIV   = `OVS_DIV,
  parameter int MSG_DEPTH = `MSG_DEPTH,
  parameter int ERR_W     = 8
) (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             rstn_in,
  // Serial control lines
  input  wire logic             rx_in,
  output logic                  tx_out,
  // Received command stream
  output logic [7:0]            cmd_byte_out,
  output logic                  cmd_valid_out,
  output logic                  cmd_last_out,
  output logic                  cmd_query_out,
  // Reply path
  input  wire logic [7:0]       reply_data_in,
  input  wire logic             reply_valid_in,
  input  wire logic             reply_last_in,
  output logic                  reply_ready_out,
  input  wire logic             noreply_in,
  // Last command error code
  input  wire logic [ERR_W-1:0] err_code_in,
  input  wire logic             err_valid_in,
  output logic [ERR_W-1:0]      last_err_out
);

  localparam int DW = $clog2(OVS_DIV);
  localparam int MW = $clog2(MSG_DEPTH + 1);

  ////////////////////////////////////////////////////////////////////////////
  // Oversample tick, 16 per bit
  logic [DW-1:0] div_cnt;
  logic          tick;

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      div_cnt <= '0;
      tick    <= 1'b0;
    end else begin
      tick    <= (div_cnt == DW'(OVS_DIV - 1));
      div_cnt <= (div_cnt == DW'(OVS_DIV - 1)) ? '0 : div_cnt + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive character: 8N1, sampled mid-bit
  logic       rx_meta;
  logic       rx_sync;
  logic       rx_act;
  logic [3:0] rx_ph;
  logic [3:0] rx_bit;
  logic [7:0] rx_sh;
  logic       rx_stb;
  logic       rx_ferr;

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
    end else begin
      rx_meta <= rx_in;
      rx_sync <= rx_meta;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rx_act  <= 1'b0;
      rx_ph   <= '0;
      rx_bit  <= '0;
      rx_sh   <= '0;
      rx_stb  <= 1'b0;
      rx_ferr <= 1'b0;
    end else begin
      rx_stb <= 1'b0;
      if (tick) begin
        if (!rx_act) begin
          if (!rx_sync) begin
            rx_act <= 1'b1;
            rx_ph  <= '0;
            rx_bit <= '0;
          end
        end else if (rx_ph == ((rx_bit == 4'h0) ? 4'h7 : 4'hF)) begin
          rx_ph <= '0;
          if (rx_bit == 4'h0 && rx_sync) begin
            rx_act <= 1'b0;
          end else if (rx_bit == 4'h9) begin
            rx_act  <= 1'b0;
            rx_stb  <= 1'b1;
            rx_ferr <= !rx_sync;
          end else begin
            rx_bit <= rx_bit + 1'b1;
            if (rx_bit != 4'h0) begin
              rx_sh <= {rx_sync, rx_sh[7:1]};
            end
          end
        end else begin
          rx_ph <= rx_ph + 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Message assembly; waits forever between characters
  serial_msg_pkg::rx_state_e rx_state;
  logic [7:0]    msg_mem [MSG_DEPTH];
  logic [MW-1:0] wr_cnt;
  logic          msg_bad;
  logic          ans_req;
  logic          ans_nak;
  logic [MW-1:0] msg_len;
  logic          ans_take;

  always_ff @(posedge clk_in) begin
    if (rx_stb && rx_state == serial_msg_pkg::RX_BODY && wr_cnt != MW'(MSG_DEPTH)) begin
      msg_mem[wr_cnt[$clog2(MSG_DEPTH)-1:0]] <= rx_sh;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rx_state      <= serial_msg_pkg::RX_HUNT;
      wr_cnt        <= '0;
      msg_bad       <= 1'b0;
      ans_req       <= 1'b0;
      ans_nak       <= 1'b0;
      msg_len       <= '0;
      cmd_query_out <= 1'b0;
    end else begin
      if (ans_take) begin
        ans_req <= 1'b0;
      end
      if (rx_stb) begin
        if (rx_sh == `CHR_STX && !rx_ferr) begin
          rx_state <= serial_msg_pkg::RX_BODY;
          wr_cnt   <= '0;
          msg_bad  <= 1'b0;
        end else if (rx_state == serial_msg_pkg::RX_BODY) begin
          if (rx_sh == `CHR_ETX && !rx_ferr) begin
            rx_state      <= serial_msg_pkg::RX_HUNT;
            ans_req       <= 1'b1;
            ans_nak       <= msg_bad;
            msg_len       <= wr_cnt;
            cmd_query_out <= (wr_cnt != '0) &&
                             (msg_mem[wr_cnt[$clog2(MSG_DEPTH)-1:0] - 1'b1] == `CHR_QUERY);
          end else if (rx_sh < `CHR_MIN || rx_ferr || wr_cnt == MW'(MSG_DEPTH)) begin
            msg_bad <= 1'b1;
          end else begin
            wr_cnt <= wr_cnt + 1'b1;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reply FIFO
  logic [8:0] rf_data;
  logic       rf_valid;
  logic       rf_pop;
  logic       reply_done;

  reply_fifo #(
    .WIDTH (9),
    .DEPTH (`FIFO_DEPTH)
  ) u_fifo (
    .clk_in        (clk_in),
    .rstn_in       (rstn_in),
    .in_data_in    ({reply_last_in, reply_data_in}),
    .in_valid_in   (reply_valid_in),
    .in_ready_out  (reply_ready_out),
    .out_data_out  (rf_data),
    .out_valid_out (rf_valid),
    .out_ready_in  (rf_pop)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Answer and reply sequencing
  serial_msg_pkg::tx_state_e tx_state;
  logic       tx_busy;
  logic       tx_go;
  logic [7:0] tx_byte;
  logic [MW-1:0] rd_idx;
  logic       dump;

  assign ans_take = (tx_state == serial_msg_pkg::TX_IDLE) && ans_req && !tx_busy;
  assign rf_pop   = (tx_state == serial_msg_pkg::TX_DATA) && !tx_busy && !tx_go;

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tx_state   <= serial_msg_pkg::TX_IDLE;
      tx_go      <= 1'b0;
      tx_byte    <= '0;
      reply_done <= 1'b0;
    end else begin
      tx_go <= 1'b0;
      // Only a last byte pushed while waiting counts; one pushed mid-frame would go stale
      if (reply_valid_in && reply_ready_out && reply_last_in &&
          tx_state == serial_msg_pkg::TX_WAIT) begin
        reply_done <= 1'b1;
      end
      unique case (tx_state)
        serial_msg_pkg::TX_IDLE: begin
          if (ans_take) begin
            tx_go    <= 1'b1;
            tx_byte  <= ans_nak ? `CHR_NAK : `CHR_ACK;
            tx_state <= serial_msg_pkg::TX_ANS;
          end
        end
        serial_msg_pkg::TX_ANS: begin
          tx_state <= (ans_nak || msg_len == '0) ? serial_msg_pkg::TX_IDLE
                                                 : serial_msg_pkg::TX_WAIT;
        end
        serial_msg_pkg::TX_WAIT: begin
          if (noreply_in) begin
            tx_state <= serial_msg_pkg::TX_IDLE;
          end else if (reply_done || !reply_ready_out) begin
            // Start only with a whole reply or a full FIFO so the gaps stay short
            tx_state <= serial_msg_pkg::TX_STX;
          end
        end
        serial_msg_pkg::TX_STX: begin
          if (!tx_busy && !tx_go) begin
            tx_go      <= 1'b1;
            tx_byte    <= `CHR_STX;
            reply_done <= 1'b0;
            tx_state   <= serial_msg_pkg::TX_DATA;
          end
        end
        serial_msg_pkg::TX_DATA: begin
          if (rf_pop && rf_valid) begin
            tx_go   <= 1'b1;
            tx_byte <= rf_data[7:0];
            if (rf_data[8]) begin
              tx_state <= serial_msg_pkg::TX_ETX;
            end
          end
        end
        serial_msg_pkg::TX_ETX: begin
          if (!tx_busy && !tx_go) begin
            tx_go    <= 1'b1;
            tx_byte  <= `CHR_ETX;
            tx_state <= serial_msg_pkg::TX_IDLE;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Hand the accepted message to the command decoder
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      dump          <= 1'b0;
      rd_idx        <= '0;
      cmd_byte_out  <= '0;
      cmd_valid_out <= 1'b0;
      cmd_last_out  <= 1'b0;
    end else begin
      cmd_valid_out <= dump;
      cmd_last_out  <= dump && (rd_idx == msg_len - 1'b1);
      cmd_byte_out  <= msg_mem[rd_idx[$clog2(MSG_DEPTH)-1:0]];
      if (tx_state == serial_msg_pkg::TX_ANS && !ans_nak && msg_len != '0) begin
        dump   <= 1'b1;
        rd_idx <= '0;
      end else if (dump) begin
        rd_idx <= rd_idx + 1'b1;
        dump   <= (rd_idx != msg_len - 1'b1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit character: 8N1, next byte loads two cycles after stop bit
  logic [9:0] tx_sh;
  logic [3:0] tx_ph;
  logic [3:0] tx_cnt;

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tx_busy <= 1'b0;
      tx_sh   <= 10'h3FF;
      tx_ph   <= '0;
      tx_cnt  <= '0;
      tx_out  <= 1'b1;
    end else begin
      tx_out <= tx_sh[0];
      if (tx_go) begin
        tx_busy <= 1'b1;
        tx_sh   <= {1'b1, tx_byte, 1'b0};
        tx_ph   <= '0;
        tx_cnt  <= '0;
      end else if (tx_busy && tick) begin
        tx_ph <= tx_ph + 1'b1;
        if (tx_ph == 4'hF) begin
          tx_sh  <= {1'b1, tx_sh[9:1]};
          tx_cnt <= tx_cnt + 1'b1;
          if (tx_cnt == 4'h9) begin
            tx_busy <= 1'b0;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Error code of the most recent command
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      last_err_out <= '0;
    end else if (err_valid_in) begin
      last_err_out <= err_code_in;
    end
  end

endmodule

// [serial_msg_regs.svh]
`ifndef SERIAL_MSG_REGS_SVH
`define SERIAL_MSG_REGS_SVH

// Framing, answer and query characters
`define CHR_STX      8'h02
`define CHR_ETX      8'h03
`define CHR_ACK      8'h06
`define CHR_NAK      8'h15
`define CHR_QUERY    8'h3F
// Lowest legal content code, decimal 32
`define CHR_MIN      8'h20

// Character timing
`define CLK_HZ       250000000
`define BAUD_DEFAULT 9600
`define OVS_RATE     16
`define OVS_DIV      (`CLK_HZ / (`BAUD_DEFAULT * `OVS_RATE))

// Receive buffer and reply FIFO sizes
`define MSG_DEPTH    32
`define FIFO_DEPTH   16

`endif

// [serial_msg_pkg.sv]
package serial_msg_pkg;

  typedef enum logic [1:0] {
    RX_HUNT = 2'b01,
    RX_BODY = 2'b10
  } rx_state_e;

  typedef enum logic [5:0] {
    TX_IDLE = 6'b000001,
    TX_ANS  = 6'b000010,
    TX_WAIT = 6'b000100,
    TX_STX  = 6'b001000,
    TX_DATA = 6'b010000,
    TX_ETX  = 6'b100000
  } tx_state_e;

endpackage

// [reply_fifo.sv]
module reply_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             rstn_in,
  // Fill side
  input  wire logic [WIDTH-1:0] in_data_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  // Drain side
  output logic [WIDTH-1:0]      out_data_out,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW:0]      next_count;
  logic             push;
  logic             pop;

  assign push         = in_valid_in && in_ready_out;
  assign pop          = out_valid_out && out_ready_in;
  assign out_data_out = mem[rd_ptr];
  assign next_count   = count + (AW+1)'(push) - (AW+1)'(pop);

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr] <= in_data_in;
    end
  end

  // Flags are registered so both handshake outputs come from flops
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wr_ptr        <= '0;
      rd_ptr        <= '0;
      count         <= '0;
      in_ready_out  <= 1'b0;
      out_valid_out <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count         <= next_count;
      in_ready_out  <= (next_count != (AW+1)'(DEPTH));
      out_valid_out <= (next_count != '0);
    end
  end

endmodule

// [serial_msg_ack_asserts.sv]
module serial_msg_ack_asserts #(
  parameter int ERR_W = 8
) (
  // Clock and reset
  input wire logic             clk_in,
  input wire logic             rstn_in,
  // Serial and command stream
  input wire logic             tx_out,
  input wire logic [7:0]       cmd_byte_out,
  input wire logic             cmd_valid_out,
  input wire logic             cmd_last_out,
  input wire logic             cmd_query_out,
  input wire logic             reply_ready_out,
  // Error code
  input wire logic [ERR_W-1:0] err_code_in,
  input wire logic             err_valid_in,
  input wire logic [ERR_W-1:0] last_err_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  ////////////////////////////////////////////////////////////////
  // A start bit lasts a full bit time, far beyond eight cycles
  sequence start_edge_s;
    $fell(tx_out);
  endsequence
  sequence start_hold_s;
    !tx_out [*8];
  endsequence

  start_bit_a: assert property (start_edge_s |-> start_hold_s)
    else $error("start bit too short");
  ready_rst_a: assert property ($rose(rstn_in) |-> !reply_ready_out ##[1:2] reply_ready_out)
    else $error("reply ready wrong after reset");
  err_store_a: assert property (err_valid_in |=> last_err_out == $past(err_code_in))
    else $error("error code not stored");
  err_hold_a: assert property (!err_valid_in |=> $stable(last_err_out))
    else $error("error code changed");
  last_valid_a: assert property (cmd_last_out |-> cmd_valid_out)
    else $error("last without valid");
  beats_run_a: assert property (cmd_valid_out && !cmd_last_out |=> cmd_valid_out)
    else $error("command burst broken");
  content_range_a: assert property (cmd_valid_out |-> cmd_byte_out >= 8'h20)
    else $error("illegal content passed");
  query_set_a: assert property (cmd_last_out && cmd_byte_out == 8'h3F |-> cmd_query_out)
    else $error("query flag not set");
  query_clr_a: assert property (cmd_last_out && cmd_byte_out != 8'h3F |-> !cmd_query_out)
    else $error("query flag set");
endmodule

bind serial_msg_ack serial_msg_ack_asserts #(.ERR_W(ERR_W)) u_serial_msg_ack_asserts (
  .clk_in(clk_in), .rstn_in(rstn_in), .tx_out(tx_out), .cmd_byte_out(cmd_byte_out),
  .cmd_valid_out(cmd_valid_out), .cmd_last_out(cmd_last_out), .cmd_query_out(cmd_query_out),
  .reply_ready_out(reply_ready_out), .err_code_in(err_code_in), .err_valid_in(err_valid_in),
  .last_err_out(last_err_out));

// [host_model.sv]
module host_model #(
  parameter int BIT = 32
) (
  // Clock
  input wire logic  clk_in,
  // Serial lines
  input wire logic  line_in,
  output logic      line_out,
  // Received characters
  output logic [7:0] rx_byte_out,
  output logic      rx_stb_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    line_out = 1'b1;
    rx_byte_out = 8'h00;
    rx_stb_out = 1'b0;
  end

  ////////////////////////////////////////////////////////////////
  // Called at a falling edge; line idles high after the stop bit
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line_out = f[i];
      repeat (BIT) @(negedge clk_in);
    end
  endtask

  ////////////////////////////////////////////////////////////////
  // Mid-bit sampling; strobe held one full cycle off the sampling edge
  always begin
    @(negedge line_in);
    repeat (BIT / 2) @(posedge clk_in);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge clk_in);
      rx_byte_out[i] = line_in;
    end
    repeat (BIT) @(posedge clk_in);
    @(negedge clk_in) rx_stb_out = 1'b1;
    @(negedge clk_in) rx_stb_out = 1'b0;
  end
endmodule

// [tb_serial_msg_ack.sv]
`include "serial_msg_regs.svh"
module tb_serial_msg_ack;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int OVS = 2;
  localparam int BIT = 16 * OVS;
  // Host answer wait, scaled down from 200 ms but still several characters long
  localparam int ANS_TMO = 4 * 10 * BIT;
  localparam int RETRIES = 3;
  logic       clk_in = 1'b0, rstn_in = 1'b0;
  logic       rx_in, tx_out, cmd_valid_out, cmd_last_out, cmd_query_out, reply_ready_out, rx_stb;
  logic       reply_valid_in = 1'b0, reply_last_in = 1'b0, noreply_in = 1'b0, err_valid_in = 1'b0;
  logic [7:0] cmd_byte_out, last_err_out, rx_byte, reply_data_in = 8'h00, err_code_in = 8'h00;
  logic [8:0] tx_q[$], cmd_q[$];
  int         miscompares = 0, compares = 0, cycles = 0;

  initial forever #2 clk_in = ~clk_in;

  serial_msg_ack #(.OVS_DIV(OVS)) u_serial_msg_ack (
    .clk_in(clk_in), .rstn_in(rstn_in), .rx_in(rx_in), .tx_out(tx_out),
    .cmd_byte_out(cmd_byte_out), .cmd_valid_out(cmd_valid_out), .cmd_last_out(cmd_last_out),
    .cmd_query_out(cmd_query_out), .reply_data_in(reply_data_in), .reply_valid_in(reply_valid_in),
    .reply_last_in(reply_last_in), .reply_ready_out(reply_ready_out), .noreply_in(noreply_in),
    .err_code_in(err_code_in), .err_valid_in(err_valid_in), .last_err_out(last_err_out));
  host_model #(.BIT(BIT)) u_host (.clk_in(clk_in), .line_in(tx_out), .line_out(rx_in),
    .rx_byte_out(rx_byte), .rx_stb_out(rx_stb));

  ////////////////////////////////////////////////////////////////
  function automatic logic [7:0] rb();
    return 8'h20 + 8'($urandom_range(223));
  endfunction

  task automatic check(input string w, input logic [8:0] e, input logic [8:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", w, e, g);
    end
  endtask

  task automatic take(ref logic [8:0] q[$], input string w, input logic [8:0] g);
    logic [8:0] e;
    e = 'x;
    if (q.size() != 0) e = q.pop_front();
    check(w, e, g);
  endtask

  task automatic frame(input logic [7:0] b[$], input bit ok, input int gap);
    u_host.send(`CHR_STX);
    foreach (b[i]) begin
      u_host.send(b[i]);
      repeat (gap) @(negedge clk_in);
      if (ok) cmd_q.push_back({i == b.size() - 1, b[i]});
    end
    u_host.send(`CHR_ETX);
    tx_q.push_back({1'b0, ok ? `CHR_ACK : `CHR_NAK});
  endtask

  task automatic wait_cmd();
    while (cmd_q.size() != 0) @(negedge clk_in);
  endtask

  // Extra characters after the queue empties pop an unknown and miscompare
  task automatic drain();
    while (tx_q.size() != 0 || cmd_q.size() != 0) @(negedge clk_in);
    repeat (12 * BIT) @(negedge clk_in);
  endtask

  task automatic reply(input logic [7:0] r[$]);
    tx_q.push_back({1'b0, `CHR_STX});
    foreach (r[i]) begin
      reply_data_in = r[i];
      reply_last_in = (i == r.size() - 1);
      reply_valid_in = 1'b1;
      tx_q.push_back({1'b0, r[i]});
      do @(posedge clk_in); while (reply_ready_out !== 1'b1);
      @(negedge clk_in);
    end
    reply_valid_in = 1'b0;
    reply_last_in = 1'b0;
    tx_q.push_back({1'b0, `CHR_ETX});
  endtask

  task automatic noreply();
    noreply_in = 1'b1;
    @(negedge clk_in) noreply_in = 1'b0;
  endtask

  // Host waits for one answer character; zero means nothing came in time
  task automatic answer(output logic [7:0] a);
    a = 8'h00;
    for (int t = 0; t < ANS_TMO; t++) begin
      @(posedge clk_in);
      if (rx_stb === 1'b1) begin
        a = rx_byte;
        break;
      end
    end
    @(negedge clk_in);
  endtask

  // Host resends on NAK or silence, bounded so it cannot lock up
  task automatic ask(input logic [7:0] b[$], input bit cut, output logic [7:0] got);
    int tries;
    tries = 0;
    got = 8'h00;
    while (got != `CHR_ACK && tries < RETRIES) begin
      if (cut) begin
        u_host.send(`CHR_STX);
        foreach (b[i]) u_host.send(b[i]);
      end else begin
        frame(b, 0, 0);
      end
      answer(got);
      tries++;
    end
  endtask

  task automatic report_and_stop();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  always @(posedge clk_in) begin
    cycles++;
    if (rx_stb) take(tx_q, "tx char", {1'b0, rx_byte});
    if (cmd_valid_out) take(cmd_q, "cmd beat", {cmd_last_out, cmd_byte_out});
    if (cycles == 80000) begin
      miscompares++;
      $display("unexpected cycles expected %0d seen %0d", 79999, cycles);
      report_and_stop();
    end
  end

  initial begin
    logic [7:0] b[$];
    logic [7:0] e;
    void'($urandom(63));
    repeat (5) @(negedge clk_in);
    rstn_in = 1'b1;
    // Query, then a reply longer than the FIFO so filling stalls
    b = {8'h41, `CHR_QUERY};
    frame(b, 1, 0);
    wait_cmd();
    check("query flag", 9'h001, {8'h00, cmd_query_out});
    b = {};
    repeat (20) b.push_back(rb());
    reply(b);
    drain();
    // Boundary codes with long idle gaps
    b = {8'h20, rb(), 8'hFF};
    frame(b, 1, 3 * BIT);
    wait_cmd();
    check("query flag", 9'h000, {8'h00, cmd_query_out});
    noreply();
    drain();
    // Bad message resent until retries run out, then the channel counts as noisy
    b = {8'h20, 8'h1F, 8'h41};
    ask(b, 0, e);
    check("noisy flag", 9'h001, {8'h00, e == `CHR_NAK});
    drain();
    for (int n = 32; n < 34; n++) begin
      b = {};
      repeat (n) b.push_back(rb());
      frame(b, n <= 32, 0);
      if (n == 32) begin
        wait_cmd();
        noreply();
      end
      drain();
    end
    // Stray character, then an aborted frame restarted by STX
    u_host.send(8'h5A);
    u_host.send(`CHR_STX);
    u_host.send(8'h51);
    b = {8'h42};
    frame(b, 1, 0);
    wait_cmd();
    noreply();
    drain();
    // Unfinished message draws no answer; the host gives up and calls the link dead
    b = {8'h41, 8'h42};
    ask(b, 1, e);
    check("dead flag", 9'h001, {8'h00, e == 8'h00});
    b = {};
    frame(b, 1, 0);
    drain();
    repeat (4) begin
      e = rb();
      err_code_in = e;
      err_valid_in = 1'b1;
      @(negedge clk_in) err_valid_in = 1'b0;
      check("last error", {1'b0, e}, {1'b0, last_err_out});
      @(negedge clk_in);
    end
    report_and_stop();
  end
endmodule
